// File: src/opt_pkg.sv
// constants shared by the output protection threshold registers
package opt_pkg;
    // register indices on the management port
    localparam logic [2:0] OPT_IDX_UV = 3'h0;
    localparam logic [2:0] OPT_IDX_OV = 3'h1;
    localparam logic [2:0] OPT_IDX_OCR = 3'h2;
    localparam logic [2:0] OPT_IDX_OCF = 3'h3;
    localparam logic [2:0] OPT_IDX_DIS = 3'h4;
    localparam logic [2:0] OPT_IDX_STAT = 3'h5;
    // power-on values
    localparam logic [15:0] OPT_UV_RST = 16'h0a0f;
    localparam logic [15:0] OPT_OV_RST = 16'h0afe;
    localparam logic [15:0] OPT_OCR_RST = 16'hbe00;
    localparam logic [15:0] OPT_OCF_RST = 16'hb900;
    localparam logic [15:0] OPT_DIS_RST = 16'h0000;
    // field positions
    localparam int OPT_HY_LSB = 8;
    localparam int OPT_THR_LSB = 0;
    localparam int OPT_OC_LSB = 6;
    localparam int OPT_DIS_BIT = 0;
    localparam logic [15:0] OPT_OC_MASK = 16'hffc0;
    // widths
    localparam int OPT_SETPT_W = 12;
    localparam int OPT_OC_W = 10;
    localparam int OPT_CW = 15;
    // voltage codes count four 10 mV steps, so shift by two
    localparam int OPT_VSTEP_SHIFT = 2;
    // safe level 0.8 V in 10 mV steps
    localparam logic [11:0] OPT_VSAFE_CODE = 12'h050;
    // timing
    localparam int OPT_CLK_HZ = 40000000;
    localparam int OPT_DIS_TIME_MS = 600;
    localparam int OPT_DIS_CYCLES = (OPT_CLK_HZ / 1000) * OPT_DIS_TIME_MS;
endpackage

// File: src/opt_det_if.sv
// threshold comparator link between the register bank and each detector
`timescale 1ns/1ps
`default_nettype none
interface opt_det_if;
    logic signed [14:0] trip;
    logic signed [14:0] clr;
    logic signed [14:0] meas;
    logic rising;
    logic flag;
    modport det (input trip, input clr, input meas, input rising, output flag);
    modport ctl (output trip, output clr, output meas, output rising, input flag);
endinterface
`default_nettype wire

// File: src/opt_hyst_det.sv
// one fault flag with trip and clear levels
`timescale 1ns/1ps
`default_nettype none
module opt_hyst_det
    import opt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    opt_det_if.det dif
);
    typedef struct packed {
        logic flag;
    } opt_det_s;

    opt_det_s st_ff;
    opt_det_s nxt_st;
    logic set_hit;
    logic clr_hit;

    assign set_hit = dif.rising ? (dif.meas > dif.trip) : (dif.meas < dif.trip);
    assign clr_hit = dif.rising ? (dif.meas <= dif.clr) : (dif.meas >= dif.clr);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        // (RULE15) set beats clear
        if (set_hit) begin
            nxt_st.flag = 1'b1;
        end else if (clr_hit) begin
            nxt_st.flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dif.flag = st_ff.flag;

    ////////////////////////////////////////////////////////////////////////
    property p_flag_rise_cause;
        @(posedge clk) disable iff (!rst_n)
        $rose(st_ff.flag) |-> $past(set_hit);
    endproperty
    a_flag_rise_cause: assert property (p_flag_rise_cause) else $error("flag set without crossing"); // RULE15

    property p_flag_hold_band;
        @(posedge clk) disable iff (!rst_n)
        (st_ff.flag && !clr_hit) |=> st_ff.flag;
    endproperty
    a_flag_hold_band: assert property (p_flag_hold_band) else $error("flag cleared inside band"); // RULE15
endmodule
`default_nettype wire

// File: src/opt_threshold_regs.sv
// output protection threshold registers with their fault and discharge logic
//
// Contract
// (RULE1) undervoltage register: hysteresis high, threshold low, 0x0A0F
// (RULE2) undervoltage trip is setpoint minus code*40mV
// (RULE3) undervoltage hysteresis in 40 mV units
// (RULE4) overvoltage register: hysteresis high, threshold low, 0x0AFE
// (RULE5) overvoltage trip is setpoint plus code*40mV
// (RULE6) overvoltage hysteresis in 40 mV units
// (RULE7) rising current code in bits 15-6, 0xBE00
// (RULE8) current code step is 100 uV shunt drop
// (RULE9) falling current register same layout, default 0xB900
// (RULE10) falling current code uses same scaling
// (RULE11) current registers bits 5-0 read zero
// (RULE12) discharge register read/write, resets to zero
// (RULE13) setpoint is 12-bit code, 10 mV steps
// (RULE14) bit 0: 600 ms timed or down to 0.8 V
// (RULE15) flags set at trip, clear past hysteresis
`timescale 1ns/1ps
`default_nettype none
module opt_threshold_regs
    import opt_pkg::*;
#(
    parameter int DIS_CYCLES = OPT_DIS_CYCLES
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [11:0] vout_setpoint,
    input wire logic [11:0] meas_vout,
    input wire logic [9:0] meas_iout,
    input wire logic discharge_start,
    output logic uv_fault,
    output logic ov_fault,
    output logic oc_fault,
    output logic discharge_active,
    output logic discharge_to_vsafe
);
    localparam int CNT_W = $clog2(DIS_CYCLES + 1);

    if (DIS_CYCLES < 1) begin : g_bad_cycles
        $error("DIS_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [15:0] uv;
        logic [15:0] ov;
        logic [15:0] ocr;
        logic [15:0] ocf;
        logic dis_sel;
        logic dis_mode;
        logic dis_on;
        logic [CNT_W-1:0] dis_cnt;
        logic [15:0] rdata;
    } opt_regs_s;

    opt_regs_s st_ff;
    opt_regs_s nxt_st;
    logic [15:0] rd_mux;
    logic wr_uv;
    logic wr_ov;
    logic wr_ocr;
    logic wr_ocf;
    logic wr_dis;

    assign wr_uv = reg_wr && (reg_addr == OPT_IDX_UV);
    assign wr_ov = reg_wr && (reg_addr == OPT_IDX_OV);
    assign wr_ocr = reg_wr && (reg_addr == OPT_IDX_OCR);
    assign wr_ocf = reg_wr && (reg_addr == OPT_IDX_OCF);
    assign wr_dis = reg_wr && (reg_addr == OPT_IDX_DIS);

    ////////////////////////////////////////////////////////////////////////
    // threshold levels, all in 10 mV or 100 uV units, signed so a trip below zero never wraps
    opt_det_if uv_if ();
    opt_det_if ov_if ();
    opt_det_if oc_if ();

    logic signed [14:0] setpt_s;
    // (RULE13) setpoint as 10 mV code
    assign setpt_s = $signed({3'b000, vout_setpoint});

    // (RULE2) undervoltage trip level
    assign uv_if.trip = setpt_s - $signed({5'b00000, st_ff.uv[OPT_THR_LSB +: 8], 2'b00});
    // (RULE3) undervoltage clear level
    assign uv_if.clr = uv_if.trip + $signed({5'b00000, st_ff.uv[OPT_HY_LSB +: 8], 2'b00});
    assign uv_if.meas = $signed({3'b000, meas_vout});
    assign uv_if.rising = 1'b0;

    // (RULE5) overvoltage trip level
    assign ov_if.trip = setpt_s + $signed({5'b00000, st_ff.ov[OPT_THR_LSB +: 8], 2'b00});
    // (RULE6) overvoltage clear level
    assign ov_if.clr = ov_if.trip - $signed({5'b00000, st_ff.ov[OPT_HY_LSB +: 8], 2'b00});
    assign ov_if.meas = $signed({3'b000, meas_vout});
    assign ov_if.rising = 1'b1;

    // (RULE8) rising code compared as shunt drop
    assign oc_if.trip = $signed({5'b00000, st_ff.ocr[OPT_OC_LSB +: OPT_OC_W]});
    // (RULE10) falling code on same scale
    assign oc_if.clr = $signed({5'b00000, st_ff.ocf[OPT_OC_LSB +: OPT_OC_W]});
    assign oc_if.meas = $signed({5'b00000, meas_iout});
    assign oc_if.rising = 1'b1;

    opt_hyst_det u_uv_det (
        .clk(clk),
        .rst_n(rst_n),
        .dif(uv_if.det)
    );

    opt_hyst_det u_ov_det (
        .clk(clk),
        .rst_n(rst_n),
        .dif(ov_if.det)
    );

    opt_hyst_det u_oc_det (
        .clk(clk),
        .rst_n(rst_n),
        .dif(oc_if.det)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (reg_addr)
            OPT_IDX_UV: rd_mux = st_ff.uv;
            OPT_IDX_OV: rd_mux = st_ff.ov;
            OPT_IDX_OCR: rd_mux = st_ff.ocr;
            OPT_IDX_OCF: rd_mux = st_ff.ocf;
            OPT_IDX_DIS: rd_mux = {15'h0000, st_ff.dis_sel};
            OPT_IDX_STAT: rd_mux = {12'h000, st_ff.dis_on, oc_if.flag, ov_if.flag, uv_if.flag};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = rd_mux;
        // (RULE1) undervoltage register write
        if (wr_uv) begin
            nxt_st.uv = reg_wdata;
        end
        // (RULE4) overvoltage register write
        if (wr_ov) begin
            nxt_st.ov = reg_wdata;
        end
        // (RULE11) low six bits never stored
        // (RULE7) rising code, low bits dropped
        if (wr_ocr) begin
            nxt_st.ocr = reg_wdata & OPT_OC_MASK;
        end
        // (RULE9) falling code, low bits dropped
        if (wr_ocf) begin
            nxt_st.ocf = reg_wdata & OPT_OC_MASK;
        end
        // (RULE12) discharge select write
        if (wr_dis) begin
            nxt_st.dis_sel = reg_wdata[OPT_DIS_BIT];
        end
        // (RULE14) discharge sequencing; mode latched at start so a write mid-way cannot cut it short
        if (discharge_start && !st_ff.dis_on) begin
            nxt_st.dis_on = 1'b1;
            nxt_st.dis_mode = st_ff.dis_sel;
            nxt_st.dis_cnt = CNT_W'(DIS_CYCLES - 1);
        end else if (st_ff.dis_on) begin
            if (st_ff.dis_mode) begin
                if (meas_vout <= OPT_VSAFE_CODE) begin
                    nxt_st.dis_on = 1'b0;
                end
            end else if (st_ff.dis_cnt == '0) begin
                nxt_st.dis_on = 1'b0;
            end else begin
                nxt_st.dis_cnt = st_ff.dis_cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff.uv <= OPT_UV_RST;
            st_ff.ov <= OPT_OV_RST;
            st_ff.ocr <= OPT_OCR_RST;
            st_ff.ocf <= OPT_OCF_RST;
            st_ff.dis_sel <= OPT_DIS_RST[OPT_DIS_BIT];
            st_ff.dis_mode <= 1'b0;
            st_ff.dis_on <= 1'b0;
            st_ff.dis_cnt <= '0;
            st_ff.rdata <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign uv_fault = uv_if.flag;
    assign ov_fault = ov_if.flag;
    assign oc_fault = oc_if.flag;
    assign discharge_active = st_ff.dis_on;
    assign discharge_to_vsafe = st_ff.dis_sel;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reset_vals;
        $rose(rst_n) |-> (reg_rdata == 16'h0000) && (st_ff.uv == 16'h0a0f) && (st_ff.ov == 16'h0afe)
            && (st_ff.ocr == 16'hbe00) && (st_ff.ocf == 16'hb900) && !st_ff.dis_sel;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad power-on values"); // RULE12

    property p_uv_wr_read;
        wr_uv ##1 (reg_addr == OPT_IDX_UV) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_uv_wr_read: assert property (p_uv_wr_read) else $error("undervoltage readback wrong"); // RULE1

    property p_ov_wr;
        wr_ov |=> st_ff.ov == $past(reg_wdata);
    endproperty
    a_ov_wr: assert property (p_ov_wr) else $error("overvoltage write lost"); // RULE4

    property p_oc_low_zero;
        reg_addr == OPT_IDX_OCR || reg_addr == OPT_IDX_OCF |=> reg_rdata[5:0] == 6'h00;
    endproperty
    a_oc_low_zero: assert property (p_oc_low_zero) else $error("current low bits not zero"); // RULE11

    property p_ocf_wr;
        wr_ocf |=> st_ff.ocf == {$past(reg_wdata[15:6]), 6'h00};
    endproperty
    a_ocf_wr: assert property (p_ocf_wr) else $error("falling current write wrong"); // RULE9

    property p_uv_set;
        ($signed({3'b000, meas_vout}) < setpt_s - $signed({5'b00000, st_ff.uv[7:0], 2'b00})) |=> uv_fault;
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("undervoltage not flagged"); // RULE2

    property p_uv_hold;
        uv_fault && ($signed({3'b000, meas_vout}) < setpt_s - $signed({5'b00000, st_ff.uv[7:0], 2'b00})
            + $signed({5'b00000, st_ff.uv[15:8], 2'b00})) && !wr_uv |=> uv_fault;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("undervoltage cleared early"); // RULE3

    property p_ov_set;
        ($signed({3'b000, meas_vout}) > setpt_s + $signed({5'b00000, st_ff.ov[7:0], 2'b00})) |=> ov_fault;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("overvoltage not flagged"); // RULE5

    property p_ov_clear;
        ov_fault && ($signed({3'b000, meas_vout}) <= setpt_s + $signed({5'b00000, st_ff.ov[7:0], 2'b00})
            - $signed({5'b00000, st_ff.ov[15:8], 2'b00})) |=> !ov_fault;
    endproperty
    a_ov_clear: assert property (p_ov_clear) else $error("overvoltage stuck"); // RULE6

    property p_oc_set;
        ({1'b0, meas_iout} > {1'b0, st_ff.ocr[15:6]}) |=> oc_fault;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent not flagged"); // RULE8

    property p_oc_clear;
        oc_fault && (meas_iout <= st_ff.ocf[15:6]) && (meas_iout <= st_ff.ocr[15:6]) |=> !oc_fault;
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("overcurrent stuck"); // RULE10

    property p_dis_vsafe;
        discharge_active && st_ff.dis_mode && (meas_vout <= 12'h050) |=> !discharge_active;
    endproperty
    a_dis_vsafe: assert property (p_dis_vsafe) else $error("discharge ran past safe level"); // RULE14

    property p_dis_timed;
        discharge_active && !st_ff.dis_mode && (st_ff.dis_cnt != '0) |=> discharge_active;
    endproperty
    a_dis_timed: assert property (p_dis_timed) else $error("timed discharge ended early"); // RULE14

    c_uv_trip: cover property ($rose(uv_fault));
    c_ov_trip: cover property ($rose(ov_fault));
    c_oc_cycle: cover property ($fell(oc_fault));
    c_dis_done: cover property ($fell(discharge_active));
endmodule
`default_nettype wire

// File: verif/opt_threshold_regs_tb.sv
// self-checking bench for the output protection threshold registers
`timescale 1ns/1ps
`default_nettype none
module opt_threshold_regs_tb
    import opt_pkg::*;
;
    localparam int DIS_N = 20;
    logic clk;
    logic rst_n;
    logic [2:0] reg_addr;
    logic reg_wr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [11:0] vout_setpoint;
    logic [11:0] meas_vout;
    logic [9:0] meas_iout;
    logic discharge_start;
    logic uv_fault;
    logic ov_fault;
    logic oc_fault;
    logic discharge_active;
    logic discharge_to_vsafe;
    logic [15:0] flags;
    int err_total;
    int checks_done;
    int n;
    logic [15:0] rst_tab [5];
    logic [15:0] ones_tab [5];

    assign flags = {13'h0000, oc_fault, ov_fault, uv_fault};

    opt_threshold_regs #(.DIS_CYCLES(DIS_N)) u_opt_threshold_regs (
        .clk(clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .vout_setpoint(vout_setpoint),
        .meas_vout(meas_vout),
        .meas_iout(meas_iout),
        .discharge_start(discharge_start),
        .uv_fault(uv_fault),
        .ov_fault(ov_fault),
        .oc_fault(oc_fault),
        .discharge_active(discharge_active),
        .discharge_to_vsafe(discharge_to_vsafe)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one-cycle write strobe, released at the next edge
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        check(reg_rdata, exp);
    endtask

    // two edges leave room for the registered flag to follow
    task automatic vstep(input logic [11:0] v, input logic [15:0] exp);
        @(posedge clk);
        meas_vout <= v;
        repeat (2) @(posedge clk);
        #1;
        check(flags, exp);
    endtask

    task automatic istep(input logic [9:0] i, input logic [15:0] exp);
        @(posedge clk);
        meas_iout <= i;
        repeat (2) @(posedge clk);
        #1;
        check(flags, exp);
    endtask

    task automatic pulse_start;
        @(posedge clk);
        discharge_start <= 1'b1;
        @(posedge clk);
        discharge_start <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        vout_setpoint = 12'h1f4;
        meas_vout = 12'h1f4;
        meas_iout = 10'h000;
        discharge_start = 1'b0;
        err_total = 0;
        checks_done = 0;
        rst_tab = '{OPT_UV_RST, OPT_OV_RST, OPT_OCR_RST, OPT_OCF_RST, OPT_DIS_RST};
        ones_tab = '{16'hffff, 16'hffff, 16'hffc0, 16'hffc0, 16'h0001};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;

        // unimplemented bits drop, read-only and unmapped places ignore writes
        for (int i = 0; i < 5; i++) begin
            wr(i[2:0], 16'hffff);
            rd(i[2:0], ones_tab[i]);
        end
        wr(3'h2, 16'ha5ff);
        rd(3'h2, 16'ha5c0);
        wr(3'h5, 16'hffff);
        rd(3'h5, 16'h0000);
        wr(3'h6, 16'hffff);
        rd(3'h6, 16'h0000);
        $display("test write_readback done");

        // a second reset in mid-run brings back every power-on value
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(i[2:0], rst_tab[i]);
        end
        rd(3'h7, 16'h0000);
        $display("test reset_values done");

        // undervoltage: trip 500-60, clear at trip+40
        vstep(12'h1b8, 16'h0000);
        vstep(12'h1b7, 16'h0001);
        vstep(12'h1df, 16'h0001);
        vstep(12'h1e0, 16'h0000);
        // overvoltage: trip 500+1016, clear at trip-40
        vstep(12'h5ec, 16'h0000);
        vstep(12'h5ed, 16'h0002);
        rd(3'h5, 16'h0002);
        vstep(12'h5c5, 16'h0002);
        vstep(12'h5c4, 16'h0000);
        // a new setpoint moves the undervoltage trip to 1000-60
        @(posedge clk);
        vout_setpoint <= 12'h3e8;
        vstep(12'h3ac, 16'h0000);
        vstep(12'h3ab, 16'h0001);
        vstep(12'h3e8, 16'h0000);
        $display("test voltage_thresholds done");

        // overcurrent: set above code 760, clear at or below 740
        istep(10'h2f8, 16'h0000);
        istep(10'h2f9, 16'h0004);
        rd(3'h5, 16'h0004);
        istep(10'h2e5, 16'h0004);
        istep(10'h2e4, 16'h0000);
        $display("test current_thresholds done");

        // timed discharge; a start while running must not extend it
        wr(3'h4, 16'h0000);
        rd(3'h4, 16'h0000);
        pulse_start();
        n = 0;
        while (discharge_active === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
            discharge_start <= (n == 5);
            #1;
        end
        check(16'(n), 16'(DIS_N));
        check({15'h0000, discharge_to_vsafe}, 16'h0000);
        $display("test timed_discharge done");

        // discharge down to the safe level of 80 codes
        wr(3'h4, 16'h0001);
        rd(3'h4, 16'h0001);
        check({15'h0000, discharge_to_vsafe}, 16'h0001);
        pulse_start();
        repeat (2 * DIS_N) @(posedge clk);
        #1;
        check({15'h0000, discharge_active}, 16'h0001);
        rd(3'h5, 16'h0008);
        vstep(12'h051, 16'h0001);
        check({15'h0000, discharge_active}, 16'h0001);
        vstep(12'h050, 16'h0001);
        check({15'h0000, discharge_active}, 16'h0000);
        $display("test safe_level_discharge done");
        close_out();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
